// file: shared/dfc_consts.svh
`ifndef DFC_CONSTS_SVH
`define DFC_CONSTS_SVH
// ----------------------------------------
// holding register numbers (bus word index)
// ----------------------------------------
`define DFC_REG_CMD 16'h9C41
`define DFC_REG_FIRST_SPEED_REFERENCE 16'h9C42
`define DFC_REG_SECOND_SPEED_REFERENCE 16'h9C43
`define DFC_REG_STAT 16'h9C44
// ----------------------------------------
// command word values of the start sequence
// ----------------------------------------
`define DFC_CW_SWITCH_ON 16'h0006
`define DFC_CW_READY_OP 16'h0007
`define DFC_CW_ENABLE_OP 16'h000F
`define DFC_CW_RAMP_OUT 16'h002F
`define DFC_CW_RAMP_IN 16'h006F
// ----------------------------------------
// command word bit positions
// ----------------------------------------
`define DFC_CW_SECOND_OFF_COAST_STOP_BIT 1
`define DFC_CW_RESET_BIT 7
`define DFC_CW_SECOND_EXTERNAL_LOCATION_BIT 11
// ----------------------------------------
// scaling
// ----------------------------------------
`define DFC_FIRST_SPEED_REFERENCE_FULL 32'sd20000
`define DFC_SECOND_SPEED_REFERENCE_FULL 32'sd10000
`define DFC_AI_MID 32'sd50
`define DFC_REF_MAX 32'sd32767
`define DFC_REF_MIN (-32'sd32768)
`define DFC_STAT_W 16
`define DFC_REF_LIMIT_MS 100
`endif

// file: shared/dfc_pkg.sv
package dfc_pkg;
    // drive state machine
    typedef enum logic [2:0] {
        DFC_NOT_READY = 3'b000,
        DFC_READY_SW_ON = 3'b001,
        DFC_READY_OP = 3'b010,
        DFC_OP_ENABLED = 3'b011,
        DFC_RAMP_OUT_EN = 3'b100,
        DFC_OPERATING = 3'b101,
        DFC_SW_ON_INHIBIT = 3'b110,
        DFC_SECOND_OFF_COAST_STOP_ACTIVE = 3'b111
    } dfc_state_t;
    // reference source selection
    typedef enum logic [1:0] {
        DFC_SRC_BUS = 2'b00,
        DFC_SRC_BUS_PLUS_AI = 2'b01,
        DFC_SRC_BUS_TIMES_AI = 2'b10
    } dfc_src_t;
endpackage : dfc_pkg

// file: rtl/dfc_ref_corr.sv
`timescale 1ns/1ns
`include "dfc_consts.svh"
// ----------------------------------------
// reference correction by analogue input, registered result
// ----------------------------------------
module dfc_ref_corr (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic signed [15:0] bus_ref,
    input wire logic signed [31:0] full_scale,
    input wire dfc_pkg::dfc_src_t src_sel,
    input wire logic [6:0] analog_input_one,
    output logic signed [15:0] corr_ref_q
);
    import dfc_pkg::*;

    logic signed [31:0] ai_s;
    logic signed [31:0] sum_v;
    logic signed [31:0] res_v;
    logic signed [15:0] corr_ref_d;

    // saturate to the signed 16-bit reference range
    function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
        if (v > `DFC_REF_MAX) begin
            sat16 = 16'sh7FFF;
        end else if (v < `DFC_REF_MIN) begin
            sat16 = 16'sh8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction : sat16

    // percentage expressed in reference counts, midpoint gives zero offset
    always_comb begin
        ai_s = $signed({25'h0000000, analog_input_one});
        sum_v = 32'sh0;
        res_v = 32'(bus_ref);
        case (src_sel)
            DFC_SRC_BUS: begin
                res_v = 32'(bus_ref);
            end
            DFC_SRC_BUS_PLUS_AI: begin
                sum_v = (ai_s - `DFC_AI_MID) * full_scale / 32'sd100;
                res_v = 32'(bus_ref) + sum_v;
            end
            DFC_SRC_BUS_TIMES_AI: begin
                res_v = 32'(bus_ref) * ai_s / `DFC_AI_MID;
            end
            default: begin
                res_v = 32'(bus_ref);
            end
        endcase
        corr_ref_d = sat16(res_v);
    end

    // result register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            corr_ref_q <= 16'sh0000;
        end else begin
            corr_ref_q <= corr_ref_d;
        end
    end
endmodule : dfc_ref_corr

// file: rtl/dfc_core.sv
`timescale 1ns/1ns
`include "dfc_consts.svh"
module dfc_core (
    input wire logic mclk,
    input wire logic rst_n,
    // holding register access from the serial link engine
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata_q,
    output logic reg_ack,
    output logic reg_err,
    // drive side inputs
    input wire logic fault_in,
    input wire logic alarm_in,
    input wire logic at_reference,
    input wire logic remote_ctrl,
    input wire logic superv1_above,
    input wire logic run_enable,
    input wire dfc_pkg::dfc_src_t first_speed_reference_src,
    input wire dfc_pkg::dfc_src_t second_speed_reference_src,
    input wire logic first_speed_reference_from_bus,
    input wire logic second_speed_reference_from_bus,
    input wire logic [6:0] analog_input_one,
    // drive side outputs
    output dfc_pkg::dfc_state_t drive_state,
    output logic [15:0] state_report_word,
    output logic second_external_location,
    output logic motor_run,
    output logic coast_stop,
    output logic ramp_out_release,
    output logic ramp_in_release,
    output logic fault_reset_pulse,
    output logic first_ref_valid,
    output logic signed [15:0] first_speed_reference,
    output logic second_ref_valid,
    output logic signed [15:0] second_speed_reference
);
    import dfc_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [15:0] command_word_q;
    logic signed [15:0] speed_reference_one_q;
    logic signed [15:0] speed_reference_two_q;
    dfc_state_t state_q;
    dfc_state_t state_d;
    logic fault_q;
    logic reset_bit_q;
    logic cw_strobe;
    logic reset_edge;
    logic [15:0] status_d;
    logic signed [15:0] corr1;
    logic signed [15:0] corr2;

    // address decode helper
    function automatic logic is_mapped(input logic [15:0] a);
        is_mapped = (a == `DFC_REG_CMD) || (a == `DFC_REG_FIRST_SPEED_REFERENCE) ||
                    (a == `DFC_REG_SECOND_SPEED_REFERENCE) || (a == `DFC_REG_STAT);
    endfunction : is_mapped

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    assign cw_strobe = reg_wr && (reg_addr == `DFC_REG_CMD);

    // command word store
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            command_word_q <= 16'h0000;
        end else if (cw_strobe) begin
            command_word_q <= reg_wdata;
        end
    end

    // reference stores, raw two's complement words
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            speed_reference_one_q <= 16'sh0000;
            speed_reference_two_q <= 16'sh0000;
        end else if (reg_wr) begin
            if (reg_addr == `DFC_REG_FIRST_SPEED_REFERENCE) begin
                speed_reference_one_q <= reg_wdata;
            end
            if (reg_addr == `DFC_REG_SECOND_SPEED_REFERENCE) begin
                speed_reference_two_q <= reg_wdata;
            end
        end
    end

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    assign reg_ack = reg_wr || reg_rd;
    assign reg_err = (reg_wr || reg_rd) &&
                     (!is_mapped(reg_addr) || (reg_wr && reg_addr == `DFC_REG_STAT));

    // read data register, status read live
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `DFC_REG_CMD: reg_rdata_q <= command_word_q;
                `DFC_REG_FIRST_SPEED_REFERENCE: reg_rdata_q <= speed_reference_one_q;
                `DFC_REG_SECOND_SPEED_REFERENCE: reg_rdata_q <= speed_reference_two_q;
                `DFC_REG_STAT: reg_rdata_q <= status_d;
                default: reg_rdata_q <= 16'h0000;
            endcase
        end
    end

    // ----------------------------------------
    // fault latch and reset edge
    // ----------------------------------------
    assign reset_edge = command_word_q[`DFC_CW_RESET_BIT] && !reset_bit_q;

    // previous value of the reset bit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reset_bit_q <= 1'b0;
        end else begin
            reset_bit_q <= command_word_q[`DFC_CW_RESET_BIT];
        end
    end

    // fault sticky; a new fault wins over reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fault_q <= 1'b0;
        end else if (fault_in) begin
            fault_q <= 1'b1;
        end else if (reset_edge) begin
            fault_q <= 1'b0;
        end
    end

    assign fault_reset_pulse = reset_edge;

    // ----------------------------------------
    // drive state machine
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            DFC_SECOND_OFF_COAST_STOP_ACTIVE: begin
                state_d = DFC_SW_ON_INHIBIT;
            end
            default: begin
                if (cw_strobe) begin
                    case (reg_wdata)
                        `DFC_CW_SWITCH_ON: state_d = DFC_READY_SW_ON;
                        `DFC_CW_READY_OP: state_d = DFC_READY_OP;
                        `DFC_CW_ENABLE_OP: state_d = DFC_OP_ENABLED;
                        `DFC_CW_RAMP_OUT: state_d = DFC_RAMP_OUT_EN;
                        `DFC_CW_RAMP_IN: state_d = DFC_OPERATING;
                        default: state_d = state_q;
                    endcase
                    if (!reg_wdata[`DFC_CW_SECOND_OFF_COAST_STOP_BIT] && state_q != DFC_SW_ON_INHIBIT &&
                        state_q != DFC_NOT_READY) begin
                        state_d = DFC_SECOND_OFF_COAST_STOP_ACTIVE;
                    end
                end
            end
        endcase
        if (fault_q && !reset_edge) begin
            state_d = DFC_SW_ON_INHIBIT;
        end
        if (reset_edge) begin
            state_d = DFC_SW_ON_INHIBIT;
        end
    end

    // state register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= DFC_NOT_READY;
        end else begin
            state_q <= state_d;
        end
    end

    assign drive_state = state_q;

    // ----------------------------------------
    // drive controls from state, location select from command word bit 11
    // ----------------------------------------
    assign motor_run = (state_q == DFC_OP_ENABLED) || (state_q == DFC_RAMP_OUT_EN) ||
                       (state_q == DFC_OPERATING);
    assign ramp_out_release = (state_q == DFC_RAMP_OUT_EN) || (state_q == DFC_OPERATING);
    assign ramp_in_release = (state_q == DFC_OPERATING);
    assign coast_stop = (state_q == DFC_SECOND_OFF_COAST_STOP_ACTIVE);
    assign second_external_location = command_word_q[`DFC_CW_SECOND_EXTERNAL_LOCATION_BIT];

    // ----------------------------------------
    // state report word
    // ----------------------------------------
    always_comb begin
        status_d = 16'h0000;
        status_d[0] = (state_q == DFC_READY_SW_ON) || (state_q == DFC_READY_OP) ||
                      motor_run;
        status_d[1] = (state_q == DFC_READY_OP) || motor_run;
        status_d[2] = motor_run;
        status_d[3] = fault_q;
        status_d[4] = (state_q != DFC_SECOND_OFF_COAST_STOP_ACTIVE);
        status_d[5] = 1'b1;
        status_d[6] = (state_q == DFC_SW_ON_INHIBIT);
        status_d[7] = alarm_in;
        status_d[8] = at_reference;
        status_d[9] = remote_ctrl;
        status_d[10] = superv1_above;
        status_d[11] = second_external_location;
        status_d[12] = run_enable;
    end

    assign state_report_word = status_d;

    // ----------------------------------------
    // reference selection and correction
    // ----------------------------------------
    dfc_ref_corr u_corr1 (
        .mclk(mclk),
        .rst_n(rst_n),
        .bus_ref(speed_reference_one_q),
        .full_scale(`DFC_FIRST_SPEED_REFERENCE_FULL),
        .src_sel(first_speed_reference_src),
        .analog_input_one(analog_input_one),
        .corr_ref_q(corr1)
    );

    dfc_ref_corr u_corr2 (
        .mclk(mclk),
        .rst_n(rst_n),
        .bus_ref(speed_reference_two_q),
        .full_scale(`DFC_SECOND_SPEED_REFERENCE_FULL),
        .src_sel(second_speed_reference_src),
        .analog_input_one(analog_input_one),
        .corr_ref_q(corr2)
    );

    // references only valid with bus source on the matching location
    assign first_ref_valid = first_speed_reference_from_bus && !second_external_location;
    assign second_ref_valid = second_speed_reference_from_bus && second_external_location;
    assign first_speed_reference = first_ref_valid ? corr1 : 16'sh0000;
    assign second_speed_reference = second_ref_valid ? corr2 : 16'sh0000;
endmodule : dfc_core

// file: sim/dfc_core_sva.sv
`timescale 1ns/1ns
`include "dfc_consts.svh"
// ----------------------------------------
// port checker for the control core
// ----------------------------------------
module dfc_core_sva (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata_q,
    input wire logic reg_err,
    input wire logic fault_in,
    input wire logic alarm_in,
    input wire logic at_reference,
    input wire logic remote_ctrl,
    input wire logic superv1_above,
    input wire logic run_enable,
    input wire dfc_pkg::dfc_state_t drive_state,
    input wire logic [15:0] state_report_word,
    input wire logic second_external_location,
    input wire logic fault_reset_pulse
);
    import dfc_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic last_b7_q;
    // bit 7 of the last command word written
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            last_b7_q <= 1'b0;
        end else if (reg_wr && reg_addr == `DFC_REG_CMD) begin
            last_b7_q <= reg_wdata[7];
        end
    end
    // command write that may step the state machine
    sequence s_cmd(v);
        reg_wr && reg_addr == `DFC_REG_CMD && reg_wdata == v && !fault_in
            && !state_report_word[3] && drive_state != DFC_SECOND_OFF_COAST_STOP_ACTIVE;
    endsequence
    // coast stop: one cycle in second-off, then inhibited
    sequence s_second_off_coast_stop;
        drive_state == DFC_SECOND_OFF_COAST_STOP_ACTIVE && !state_report_word[4]
            ##1 drive_state == DFC_SW_ON_INHIBIT && state_report_word[6];
    endsequence
    a_reset_idle: assert property ($rose(rst_n) |-> drive_state == DFC_NOT_READY)
        else $error("state not idle after reset");
    a_switch_on: assert property (s_cmd(16'h0006) |=> drive_state == DFC_READY_SW_ON)
        else $error("switch-on command not taken");
    a_ready_op: assert property (s_cmd(16'h0007) |=> drive_state == DFC_READY_OP)
        else $error("ready command not taken");
    a_coast_stop: assert property (reg_wr && reg_addr == `DFC_REG_CMD && !reg_wdata[1]
        && !reg_wdata[7] && !fault_in && drive_state inside {[DFC_READY_SW_ON:DFC_OPERATING]}
        |=> s_second_off_coast_stop)
        else $error("coast stop sequence wrong");
    a_input_bits: assert property ($stable({alarm_in, at_reference, remote_ctrl,
        superv1_above, run_enable}) |-> state_report_word[15:7] == {3'b000, run_enable,
        second_external_location, superv1_above, remote_ctrl, at_reference, alarm_in})
        else $error("status input bits wrong");
    a_second_external_location_latch: assert property (reg_wr && reg_addr == `DFC_REG_CMD |=>
        second_external_location == $past(reg_wdata[11]))
        else $error("location select not stored");
    a_bad_read: assert property (reg_rd && !(reg_addr inside {[`DFC_REG_CMD:`DFC_REG_STAT]})
        |-> reg_err ##1 reg_rdata_q == 16'h0000)
        else $error("unmapped read not refused");
    a_fault_clear: assert property (reg_wr && reg_addr == `DFC_REG_CMD && reg_wdata[7]
        && !last_b7_q |-> ##[1:2] fault_reset_pulse)
        else $error("fault reset pulse missing");
endmodule : dfc_core_sva

bind dfc_core dfc_core_sva chk (.mclk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata_q, .reg_err, .fault_in, .alarm_in, .at_reference, .remote_ctrl, .superv1_above,
    .run_enable, .drive_state, .state_report_word, .second_external_location,
    .fault_reset_pulse);

// file: sim/dfc_master_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// bus master station, one register transfer at a time
// ----------------------------------------
module dfc_master_model #(
    parameter int STEP_GAP = 50
) (
    input wire logic mclk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata_q,
    input wire logic reg_ack,
    input wire logic reg_err
);
    int n_tmo = 0;
    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end
    // drive after a falling edge, hold until the acknowledged rising edge
    task automatic xfer(input logic wr, input logic [15:0] addr, input logic [15:0] data,
        output logic [15:0] rdata, output logic err);
        int i;
        @(negedge mclk);
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = addr;
        reg_wdata = data;
        for (i = 0; i < 8; i++) begin
            @(posedge mclk);
            if (reg_ack === 1'b1) break;
        end
        if (i == 8) n_tmo++;
        err = reg_err;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~addr; // released lines do not keep old value
        reg_wdata = ~data;
        rdata = reg_rdata_q;
    endtask : xfer
    // settle time between start steps, scaled down
    task automatic step_gap;
        repeat (STEP_GAP) @(posedge mclk);
    endtask : step_gap
endmodule : dfc_master_model

// file: sim/drive_fieldbus_control_status_test.sv
`timescale 1ns/1ns
`include "dfc_consts.svh"
module drive_fieldbus_control_status_test;
    import dfc_pkg::*;
    typedef struct {logic [15:0] cw; dfc_state_t st; int b;} dfc_row_t;
    logic mclk, rst_n, reg_wr, reg_rd, reg_ack, reg_err, fault_in, alarm_in, at_reference;
    logic remote_ctrl, superv1_above, run_enable, first_speed_reference_from_bus, second_speed_reference_from_bus, er, seen;
    logic second_external_location, motor_run, coast_stop, ramp_out_release, ramp_in_release;
    logic fault_reset_pulse, first_ref_valid, second_ref_valid;
    logic [15:0] reg_addr, reg_wdata, reg_rdata_q, state_report_word, rd, ex;
    logic [6:0] analog_input_one;
    logic signed [15:0] first_speed_reference, second_speed_reference;
    dfc_src_t first_speed_reference_src, second_speed_reference_src;
    dfc_state_t drive_state;
    int tests_run = 0;
    int n_mismatch = 0;
    // start sequence: command, state reached, status flag bit
    dfc_row_t rows [5] = '{'{`DFC_CW_SWITCH_ON, DFC_READY_SW_ON, 0},
        '{`DFC_CW_READY_OP, DFC_READY_OP, 1}, '{`DFC_CW_ENABLE_OP, DFC_OP_ENABLED, 2},
        '{`DFC_CW_RAMP_OUT, DFC_RAMP_OUT_EN, 2}, '{`DFC_CW_RAMP_IN, DFC_OPERATING, 2}};
    // reference 5000 (25 %), corrections with input 30 % and 50 %
    dfc_src_t rsrc [4] = '{DFC_SRC_BUS, DFC_SRC_BUS_PLUS_AI, DFC_SRC_BUS_PLUS_AI,
        DFC_SRC_BUS_TIMES_AI};
    logic [6:0] rai [4] = '{7'h1E, 7'h1E, 7'h32, 7'h1E};
    logic [15:0] rexp [4] = '{16'h1388, 16'h03E8, 16'h1388, 16'h0BB8};
    dfc_core uut (.mclk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q,
        .reg_ack, .reg_err, .fault_in, .alarm_in, .at_reference, .remote_ctrl, .superv1_above,
        .run_enable, .first_speed_reference_src, .second_speed_reference_src, .first_speed_reference_from_bus, .second_speed_reference_from_bus, .analog_input_one,
        .drive_state, .state_report_word, .second_external_location, .motor_run, .coast_stop,
        .ramp_out_release, .ramp_in_release, .fault_reset_pulse, .first_ref_valid,
        .first_speed_reference, .second_ref_valid, .second_speed_reference);
    dfc_master_model #(.STEP_GAP(20)) m (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata_q, .reg_ack, .reg_err);
    // 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        m.xfer(1'b1, a, d, rd, er);
    endtask : wr
    task automatic rds;
        m.xfer(1'b0, `DFC_REG_STAT, 16'h0000, rd, er);
    endtask : rds
    task automatic results;
        n_mismatch += m.n_tmo;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    // a bus transfer without answer ends the run
    always @(negedge mclk) if (m.n_tmo != 0) results();
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        {fault_in, alarm_in, at_reference, remote_ctrl, superv1_above, run_enable} = '0;
        {first_speed_reference_from_bus, second_speed_reference_from_bus} = 2'b00;
        first_speed_reference_src = DFC_SRC_BUS;
        second_speed_reference_src = DFC_SRC_BUS;
        analog_input_one = 7'h32;
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        rds();
        cmp("reset status", 16'h0030, rd);
        foreach (rows[i]) begin
            wr(`DFC_REG_CMD, rows[i].cw);
            if (i == 0) m.step_gap();
            cmp("state", 16'(rows[i].st), 16'(drive_state));
            rds();
            cmp("state flag", 16'h0001, {15'h0, rd[rows[i].b]});
            cmp("status high", 16'h0003, {4'h0, rd[15:4]});
        end
        cmp("ramp input", 16'h0001, {15'h0, ramp_in_release});
        cmp("ramp output", 16'h0001, {15'h0, ramp_out_release});
        cmp("motor run", 16'h0001, {15'h0, motor_run});
        cmp("no coast", 16'h0000, {15'h0, coast_stop});
        // one status input at a time
        for (int k = 0; k < 5; k++) begin
            {run_enable, superv1_above, remote_ctrl, at_reference, alarm_in} = 5'(1 << k);
            ex = (k == 4) ? 16'h1000 : 16'h0080 << k;
            rds();
            cmp("inputs", ex, rd & 16'hFF80);
        end
        {run_enable, superv1_above, remote_ctrl, at_reference, alarm_in} = 5'h00;
        // first reference through each correction mode
        first_speed_reference_from_bus = 1'b1;
        wr(`DFC_REG_FIRST_SPEED_REFERENCE, 16'h1388);
        foreach (rsrc[j]) begin
            first_speed_reference_src = rsrc[j];
            analog_input_one = rai[j];
            repeat (3) @(negedge mclk);
            cmp("first_speed_reference", rexp[j], first_speed_reference);
        end
        // coast stop with second location selected
        wr(`DFC_REG_CMD, 16'h0800);
        cmp("coast state", 16'(DFC_SECOND_OFF_COAST_STOP_ACTIVE), 16'(drive_state));
        cmp("second_off_coast_stop flag", 16'h0000, {15'h0, state_report_word[4]});
        cmp("coast out", 16'h0001, {15'h0, coast_stop});
        @(negedge mclk);
        cmp("coast report", 16'h0840, state_report_word & 16'h0840);
        // second reference, negative, multiplicative
        second_speed_reference_from_bus = 1'b1;
        second_speed_reference_src = DFC_SRC_BUS_TIMES_AI;
        wr(`DFC_REG_SECOND_SPEED_REFERENCE, 16'hD8F0);
        repeat (3) @(negedge mclk);
        cmp("second_speed_reference", 16'hE890, second_speed_reference);
        cmp("first_speed_reference gated", 16'h0000, first_speed_reference);
        cmp("first_speed_reference valid", 16'h0000, {15'h0, first_ref_valid});
        cmp("second_speed_reference valid", 16'h0001, {15'h0, second_ref_valid});
        // fault, then reset by bit 7 edge
        fault_in = 1'b1;
        repeat (2) @(negedge mclk);
        fault_in = 1'b0;
        cmp("fault state", 16'(DFC_SW_ON_INHIBIT), 16'(drive_state));
        cmp("fault flag", 16'h0008, state_report_word & 16'h0008);
        wr(`DFC_REG_CMD, 16'h0000);
        wr(`DFC_REG_CMD, 16'h0080);
        seen = 1'b0;
        repeat (3) begin
            seen |= fault_reset_pulse;
            @(negedge mclk);
        end
        cmp("reset pulse", 16'h0001, {15'h0, seen});
        cmp("fault cleared", 16'h0000, state_report_word & 16'h0008);
        // refused accesses
        m.xfer(1'b0, 16'h9C45, 16'h0000, rd, er);
        cmp("unmapped err", 16'h0001, {15'h0, er});
        cmp("unmapped data", 16'h0000, rd);
        wr(`DFC_REG_STAT, 16'hFFFF);
        cmp("status write", 16'h0001, {15'h0, er});
        // reset in mid-run
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        cmp("rerun state", 16'h0000, 16'(drive_state));
        results();
    end
endmodule : drive_fieldbus_control_status_test
